/* shared/cdbg_map.vh */
// Register offsets, field positions and the interrupt mask reset value of the debug entry block.
`ifndef CDBG_MAP_VH
`define CDBG_MAP_VH

`define CDBG_ADDR_W          12
`define CDBG_DATA_W          32

`define CDBG_OFF_CTRL        12'h000
`define CDBG_OFF_STATUS      12'h004
`define CDBG_OFF_INT_STAT    12'h008
`define CDBG_OFF_INT_MASK    12'h00c
`define CDBG_OFF_RX_DATA     12'h010
`define CDBG_OFF_TX_DATA     12'h014

`define CDBG_CTRL_HALT_REQ   1
`define CDBG_CTRL_RESUME     2

`define CDBG_ST_HALTED       0
`define CDBG_ST_DATA_PEND    1
`define CDBG_ST_RX_EMPTY     2
`define CDBG_ST_TX_EMPTY     3
`define CDBG_ST_BUS_DIS      4
`define CDBG_ST_ENABLE       5

`define CDBG_INT_ENTER       0
`define CDBG_INT_EXIT        1
`define CDBG_INT_RX_TAKEN    2
`define CDBG_INT_TX_FILLED   3
`define CDBG_INT_W           4

`define CDBG_INT_MASK_RST    4'h0
`define CDBG_CHAIN_W         4
`define CDBG_CHAIN_CORE      4'h0
`define CDBG_CHAIN_ICE       4'h4

`endif

/* design/cdbg_sync.v */
// Two flip-flop synchroniser for signals that come from outside the pclk domain.
`timescale 1ns/1ps
`default_nettype none

module cdbg_sync #(
    parameter WIDTH = 1
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

`default_nettype wire

/* design/cdbg_entry.v */
// Debug entry control: breakpoint and halt request handling, comms flags, scan bus disable.
`timescale 1ns/1ps
`default_nettype none
`include "cdbg_map.vh"

module cdbg_entry (
    input  wire                     pclk,
    input  wire                     presetn,
    input  wire                     psel,
    input  wire                     penable,
    input  wire                     pwrite,
    input  wire [`CDBG_ADDR_W-1:0]  paddr,
    input  wire [`CDBG_DATA_W-1:0]  pwdata,
    output wire [`CDBG_DATA_W-1:0]  prdata,
    output wire                     pready,
    output wire                     pslverr,
    input  wire                     ext_breakpoint_in,
    input  wire                     ext_halt_request,
    input  wire                     debug_feature_enable,
    input  wire                     tck,
    input  wire                     scan_intest,
    input  wire [`CDBG_CHAIN_W-1:0] scan_chain_sel,
    input  wire                     core_access_done,
    input  wire                     core_access_is_fetch,
    input  wire                     core_pipe_advance,
    input  wire                     core_pipe_flush,
    input  wire                     core_instr_done,
    input  wire                     core_resume,
    input  wire                     core_rx_read,
    output wire [`CDBG_DATA_W-1:0]  core_rx_data,
    input  wire                     core_tx_write,
    input  wire [`CDBG_DATA_W-1:0]  core_tx_data,
    output wire                     internal_halt_request,
    output wire                     halted_state_ack,
    output wire                     comm_rx_buffer_flag,
    output wire                     comm_tx_buffer_flag,
    output wire                     scan_bus_disable,
    output wire                     irq
);

    localparam ST_RUN  = 1'b0;
    localparam ST_HALT = 1'b1;

    function hit;
        input [`CDBG_ADDR_W-1:0] addr;
        input [`CDBG_ADDR_W-1:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    // Pin inputs synchronised before use.
    wire                     bp_s;
    wire                     hreq_s;
    wire                     en_s;
    wire                     tck_s;
    wire                     intest_s;
    wire [`CDBG_CHAIN_W-1:0] chain_s;

    cdbg_sync #(
        .WIDTH (1)
    ) u_sync_bp (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (ext_breakpoint_in),
        .sync_out (bp_s)
    );

    cdbg_sync #(
        .WIDTH (1)
    ) u_sync_hreq (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (ext_halt_request),
        .sync_out (hreq_s)
    );

    cdbg_sync #(
        .WIDTH (1)
    ) u_sync_en (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (debug_feature_enable),
        .sync_out (en_s)
    );

    cdbg_sync #(
        .WIDTH (2 + `CDBG_CHAIN_W)
    ) u_sync_scan (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({tck, scan_intest, scan_chain_sel}),
        .sync_out ({tck_s, intest_s, chain_s})
    );

    // APB decode.
    wire wr_en = psel && penable && pwrite;
    wire rd_en = psel && penable && !pwrite;
    wire mapped = hit(paddr, `CDBG_OFF_CTRL) || hit(paddr, `CDBG_OFF_STATUS) ||
                  hit(paddr, `CDBG_OFF_INT_STAT) || hit(paddr, `CDBG_OFF_INT_MASK) ||
                  hit(paddr, `CDBG_OFF_RX_DATA) || hit(paddr, `CDBG_OFF_TX_DATA);
    wire wr_ctrl  = wr_en && hit(paddr, `CDBG_OFF_CTRL);
    wire wr_istat = wr_en && hit(paddr, `CDBG_OFF_INT_STAT);
    wire wr_imask = wr_en && hit(paddr, `CDBG_OFF_INT_MASK);
    wire wr_rx    = wr_en && hit(paddr, `CDBG_OFF_RX_DATA);
    wire rd_tx    = rd_en && hit(paddr, `CDBG_OFF_TX_DATA);

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    reg                      halt_req_bit;
    reg                      state;
    reg                      mark_dec;
    reg                      data_pend;
    reg                      rx_full;
    reg                      tx_full;
    reg [`CDBG_DATA_W-1:0]   rx_word;
    reg [`CDBG_DATA_W-1:0]   tx_word;
    reg [`CDBG_INT_W-1:0]    int_stat;
    reg [`CDBG_INT_W-1:0]    int_mask;
    reg [`CDBG_DATA_W-1:0]   rdata;
    reg                      tck_d;
    reg                      bus_dis;
    reg                      next_state;

    wire feat_on = en_s;

    assign internal_halt_request = hreq_s || halt_req_bit;

    wire bp_fetch = feat_on && bp_s && core_access_done && core_access_is_fetch;
    wire bp_data  = feat_on && bp_s && core_access_done && !core_access_is_fetch;

    wire fetch_hit = core_pipe_advance && mark_dec && !core_pipe_flush;

    wire instr_hit = core_instr_done && (data_pend || internal_halt_request);

    wire enter = feat_on && (state == ST_RUN) && (fetch_hit || instr_hit);
    wire sw_resume = wr_ctrl && pwdata[`CDBG_CTRL_RESUME];
    wire leave = (state == ST_HALT) && (core_resume || sw_resume || !feat_on);

    always @* begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (enter) begin
                    next_state = ST_HALT;
                end
            end
            ST_HALT: begin
                if (leave) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    assign halted_state_ack = (state == ST_HALT);

    // A fetch mark waits in the decode slot until the next advance carries it
    // into execute; a flush discards it, so a fetch that never executes is harmless.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mark_dec <= 1'b0;
        end else if (!feat_on || core_pipe_flush) begin
            mark_dec <= 1'b0;
        end else begin
            if (core_pipe_advance) begin
                mark_dec <= bp_fetch;
            end else if (bp_fetch) begin
                mark_dec <= 1'b1;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_pend <= 1'b0;
        end else if (!feat_on) begin
            data_pend <= 1'b0;
        end else if (bp_data) begin
            data_pend <= 1'b1;
        end else if (enter) begin
            data_pend <= 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_req_bit <= 1'b0;
        end else if (wr_ctrl) begin
            halt_req_bit <= pwdata[`CDBG_CTRL_HALT_REQ];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_full <= 1'b0;
            rx_word <= 32'h0000_0000;
        end else if (wr_rx) begin
            rx_full <= 1'b1;
            rx_word <= pwdata;
        end else if (core_rx_read) begin
            rx_full <= 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_full <= 1'b0;
            tx_word <= 32'h0000_0000;
        end else if (core_tx_write) begin
            tx_full <= 1'b1;
            tx_word <= core_tx_data;
        end else if (rd_tx) begin
            tx_full <= 1'b0;
        end
    end

    assign comm_rx_buffer_flag = !rx_full;
    assign comm_tx_buffer_flag = !tx_full;
    assign core_rx_data        = rx_word;

    wire tck_fall = tck_d && !tck_s;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tck_d   <= 1'b0;
            bus_dis <= 1'b0;
        end else begin
            tck_d <= tck_s;
            if (tck_fall) begin
                bus_dis <= intest_s && ((chain_s == `CDBG_CHAIN_CORE) ||
                                        (chain_s == `CDBG_CHAIN_ICE));
            end
        end
    end

    assign scan_bus_disable = bus_dis;

    // Events; a set in the same cycle as a write-one clear wins.
    wire [`CDBG_INT_W-1:0] int_set;
    assign int_set[`CDBG_INT_ENTER]     = (state == ST_RUN) && (next_state == ST_HALT);
    assign int_set[`CDBG_INT_EXIT]      = (state == ST_HALT) && (next_state == ST_RUN);
    assign int_set[`CDBG_INT_RX_TAKEN]  = rx_full && core_rx_read && !wr_rx;
    assign int_set[`CDBG_INT_TX_FILLED] = core_tx_write;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat <= {`CDBG_INT_W{1'b0}};
            int_mask <= `CDBG_INT_MASK_RST;
        end else begin
            if (wr_istat) begin
                int_stat <= (int_stat & ~pwdata[`CDBG_INT_W-1:0]) | int_set;
            end else begin
                int_stat <= int_stat | int_set;
            end
            if (wr_imask) begin
                int_mask <= pwdata[`CDBG_INT_W-1:0];
            end
        end
    end

    assign irq = |(int_stat & int_mask);

    // Read data is registered during the setup cycle so the zero-wait access
    // phase presents a stable word.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            rdata <= 32'h0000_0000;
            if (hit(paddr, `CDBG_OFF_CTRL)) begin
                rdata[`CDBG_CTRL_HALT_REQ] <= halt_req_bit;
            end
            if (hit(paddr, `CDBG_OFF_STATUS)) begin
                rdata[`CDBG_ST_HALTED]    <= (state == ST_HALT);
                rdata[`CDBG_ST_DATA_PEND] <= data_pend;
                rdata[`CDBG_ST_RX_EMPTY]  <= !rx_full;
                rdata[`CDBG_ST_TX_EMPTY]  <= !tx_full;
                rdata[`CDBG_ST_BUS_DIS]   <= bus_dis;
                rdata[`CDBG_ST_ENABLE]    <= feat_on;
            end
            if (hit(paddr, `CDBG_OFF_INT_STAT)) begin
                rdata[`CDBG_INT_W-1:0] <= int_stat;
            end
            if (hit(paddr, `CDBG_OFF_INT_MASK)) begin
                rdata[`CDBG_INT_W-1:0] <= int_mask;
            end
            if (hit(paddr, `CDBG_OFF_RX_DATA)) begin
                rdata <= rx_word;
            end
            if (hit(paddr, `CDBG_OFF_TX_DATA)) begin
                rdata <= tx_word;
            end
        end
    end

    assign prdata = rdata;

endmodule

`default_nettype wire

/* sim/cdbg_entry_chk.sv */
// Port-level checks of the debug entry block.
`timescale 1ns/1ps
`default_nettype none
`include "cdbg_map.vh"
module cdbg_entry_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        core_pipe_advance,
    input wire logic        core_instr_done,
    input wire logic        core_resume,
    input wire logic        core_rx_read,
    input wire logic        core_tx_write,
    input wire logic        debug_feature_enable,
    input wire logic        tck,
    input wire logic        internal_halt_request,
    input wire logic        halted_state_ack,
    input wire logic        comm_rx_buffer_flag,
    input wire logic        comm_tx_buffer_flag,
    input wire logic        scan_bus_disable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_resume_drop;
        halted_state_ack && core_resume |=> !halted_state_ack;
    endproperty
    a_resume_drop: assert property (p_resume_drop) else $error("ack kept");
    property p_entry_cause;
        $rose(halted_state_ack) |-> $past(core_instr_done) || $past(core_pipe_advance);
    endproperty
    a_entry_cause: assert property (p_entry_cause) else $error("ack no cause");
    property p_req_entry;
        debug_feature_enable[*4] ##0 (internal_halt_request && core_instr_done
            && !core_resume) |=> halted_state_ack;
    endproperty
    a_req_entry: assert property (p_req_entry) else $error("no halt");
    property p_rx_fill;
        psel && penable && pwrite && paddr == `CDBG_OFF_RX_DATA && !core_rx_read
            |=> !comm_rx_buffer_flag;
    endproperty
    a_rx_fill: assert property (p_rx_fill) else $error("rx flag high");
    property p_rx_take;
        core_rx_read && !(psel && penable && pwrite) |=> comm_rx_buffer_flag;
    endproperty
    a_rx_take: assert property (p_rx_take) else $error("rx flag low");
    property p_tx_fill;
        core_tx_write |=> !comm_tx_buffer_flag;
    endproperty
    a_tx_fill: assert property (p_tx_fill) else $error("tx flag high");
    property p_tx_take;
        psel && penable && !pwrite && paddr == `CDBG_OFF_TX_DATA && !core_tx_write
            |=> comm_tx_buffer_flag;
    endproperty
    a_tx_take: assert property (p_tx_take) else $error("tx flag low");
    property p_bdis_edge;
        $changed(scan_bus_disable) |-> !$past(tck, 3);
    endproperty
    a_bdis_edge: assert property (p_bdis_edge) else $error("bus disable moved");
endmodule
`default_nettype wire

/* sim/cdbg_far_model.sv */
// Behavioural external debug hardware driving the halt, breakpoint and scan pins.
`timescale 1ns/1ps
`default_nettype none
module cdbg_far_model (
    input  wire logic       pclk,
    output var  logic       ext_breakpoint_in,
    output var  logic       ext_halt_request,
    output var  logic       debug_feature_enable,
    output var  logic       tck,
    output var  logic       scan_intest,
    output var  logic [3:0] scan_chain_sel
);
    initial begin
        ext_breakpoint_in = 1'h0;
        ext_halt_request = 1'h0;
        debug_feature_enable = 1'h0;
        tck = 1'h1;
        scan_intest = 1'h0;
        scan_chain_sel = 4'h0;
    end
    task automatic pins(input logic en, input logic rq, input logic bp);
        debug_feature_enable <= en;
        ext_halt_request <= rq;
        ext_breakpoint_in <= bp;
    endtask
    // Test clock stands high between frames and runs far below pclk/4.
    task automatic scan(input logic it, input logic [3:0] ch);
        scan_intest <= it;
        scan_chain_sel <= ch;
        for (int i = 0; i < 16; i++) begin
            @(posedge pclk);
            tck <= (i >= 8);
        end
    endtask
endmodule
`default_nettype wire

/* sim/cdbg_entry_tb.sv */
// Self-checking bench for the debug entry block.
`timescale 1ns/1ps
`default_nettype none
`include "cdbg_map.vh"
module cdbg_entry_tb;
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, txd = 32'h0, q, prdata, rxd;
    logic [7:0]  cv = 8'h00;
    logic        e, pready, pslverr, ihr, ack, rxf, txf, bdis, irq, bp, rq, en, tck, itst;
    logic [3:0]  chs;
    integer      err_total = 0, compares = 0;
    always #4 pclk = ~pclk;
    cdbg_entry DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_breakpoint_in(bp), .ext_halt_request(rq),
        .debug_feature_enable(en), .tck(tck), .scan_intest(itst), .scan_chain_sel(chs),
        .core_access_done(cv[7]), .core_access_is_fetch(cv[6]), .core_pipe_advance(cv[5]),
        .core_pipe_flush(cv[4]), .core_instr_done(cv[3]), .core_resume(cv[2]),
        .core_rx_read(cv[1]), .core_rx_data(rxd), .core_tx_write(cv[0]),
        .core_tx_data(txd), .internal_halt_request(ihr), .halted_state_ack(ack),
        .comm_rx_buffer_flag(rxf), .comm_tx_buffer_flag(txf), .scan_bus_disable(bdis),
        .irq(irq));
    cdbg_far_model far (.pclk(pclk), .ext_breakpoint_in(bp), .ext_halt_request(rq),
        .debug_feature_enable(en), .tck(tck), .scan_intest(itst), .scan_chain_sel(chs));
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic cyc(input integer n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    // Bits: access, fetch, advance, flush, instr done, resume, rx read, tx write.
    task automatic hit(input logic [7:0] v);
        cv <= v;
        @(posedge pclk);
        cv <= 8'h00;
        cyc(2);
    endtask
    task automatic t_reset;
        apb(1'h0, `CDBG_OFF_STATUS, 32'h0);
        chk("status", 32'h0000000c, q);
        apb(1'h0, 12'h020, 32'h0);
        chk("unmapped", 1, e);
    endtask
    task automatic t_req;
        far.pins(1'h1, 1'h1, 1'h0);
        cyc(4);
        chk("ihr", 1, ihr);
        apb(1'h1, `CDBG_OFF_INT_MASK, 32'h1);
        hit(8'h08);
        chk("ack", 1, ack);
        chk("irq", 1, irq);
        far.pins(1'h1, 1'h0, 1'h0);
        apb(1'h1, `CDBG_OFF_INT_STAT, 32'h1);
        hit(8'h04);
        chk("ack", 0, ack);
        chk("irq masked", 0, irq);
        apb(1'h1, `CDBG_OFF_INT_STAT, 32'hf);
        apb(1'h1, `CDBG_OFF_CTRL, 32'h2);
        chk("ihr ctrl", 1, ihr);
        hit(8'h08);
        chk("ack", 1, ack);
        apb(1'h1, `CDBG_OFF_CTRL, 32'h4);
        chk("ack", 0, ack);
        chk("ihr", 0, ihr);
    endtask
    task automatic t_bp;
        far.pins(1'h1, 1'h0, 1'h1);
        cyc(3);
        hit(8'h80);
        chk("ack early", 0, ack);
        apb(1'h0, `CDBG_OFF_STATUS, 32'h0);
        chk("status", 32'h0000002e, q);
        hit(8'h08);
        chk("ack data", 1, ack);
        hit(8'h04);
        hit(8'hc0);
        hit(8'h10);
        hit(8'h08);
        chk("ack flushed", 0, ack);
        hit(8'he0);
        far.pins(1'h1, 1'h0, 1'h0);
        chk("ack decode", 0, ack);
        hit(8'h20);
        chk("ack execute", 1, ack);
        hit(8'h04);
        far.pins(1'h0, 1'h1, 1'h0);
        cyc(4);
        hit(8'h08);
        chk("ack disabled", 0, ack);
        far.pins(1'h1, 1'h0, 1'h0);
    endtask
    task automatic t_comms;
        apb(1'h1, `CDBG_OFF_RX_DATA, 32'h5a5a0001);
        chk("rx flag", 0, rxf);
        chk("rx word", 32'h5a5a0001, rxd);
        hit(8'h02);
        chk("rx flag", 1, rxf);
        txd <= 32'hc3c30002;
        hit(8'h01);
        chk("tx flag", 0, txf);
        apb(1'h0, `CDBG_OFF_TX_DATA, 32'h0);
        chk("tx word", 32'hc3c30002, q);
        chk("tx flag", 1, txf);
    endtask
    task automatic t_scan;
        logic [5:0] tv [4] = '{6'h21, 6'h29, 6'h26, 6'h00};
        for (int i = 0; i < 4; i++) begin
            far.scan(tv[i][5], tv[i][4:1]);
            chk("bus disable", tv[i][0], bdis);
        end
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        cyc(4);
        presetn <= 1'h1;
        cyc(3);
        t_reset;
        t_req;
        t_bp;
        t_comms;
        t_scan;
        tally_and_finish;
    end
    initial begin
        #100000;
        err_total++;
        tally_and_finish;
    end
endmodule
bind cdbg_entry cdbg_entry_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .core_pipe_advance(core_pipe_advance),
    .core_instr_done(core_instr_done), .core_resume(core_resume),
    .core_rx_read(core_rx_read), .core_tx_write(core_tx_write),
    .debug_feature_enable(debug_feature_enable), .tck(tck),
    .internal_halt_request(internal_halt_request), .halted_state_ack(halted_state_ack),
    .comm_rx_buffer_flag(comm_rx_buffer_flag), .comm_tx_buffer_flag(comm_tx_buffer_flag),
    .scan_bus_disable(scan_bus_disable));
`default_nettype wire
